// ===== bench/stcl_channel_test.sv
// self-checking bench for the channel control block
// assumes zero-wait apb and the lane model in stcl_link_rx
`timescale 1ns/100ps
`default_nettype none
module stcl_channel_test;
	import stcl_pkg::*;
	logic ref_clk_in, resetn_in, psel_in, penable_in, pwrite_in;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic pready_out, pslverr_out, err;
	logic [WORD_W-1:0] tx_word_in;
	logic tx_word_valid_in, tx_word_ready_out, tx_force_elecidle_in;
	logic tx_serial_out, tx_serial_oe_out, rxdet_pulse_out, rxdet_reflect_in;
	logic lock_to_data_in, lock_to_ref_in, pll_ref_locked_in, freq_in_ppm_in;
	logic rx_pll_locked_out, rx_freqlocked_out, pll_powerdown_out;
	logic [4:0] pll_mult_out;
	logic [1:0] pll_bw_out;
	logic [3:0] eq_gain_out, eq_adapt_level_in, reconfig_preemph_in, preemph_out;
	logic eq_adapt_pd_out, reconfig_we_in, irq_out;
	int mismatches = 0;
	int total_checks = 0;
	stcl_channel dut_u (.*);
	stcl_link_rx #(.PRESENT(1'b1)) rx_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.oe_in(tx_serial_oe_out), .pulse_in(rxdet_pulse_out), .reflect_out(rxdet_reflect_in));
	// ----------------------------------------
	// clock and helpers
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	task automatic close_out;
		if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
		total_checks++;
		if (act !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, act, exp);
		end
	endtask
	task automatic cmp_bit(input logic act, input logic exp);
		total_checks++;
		if (act !== exp) begin
			mismatches++;
			$display("mismatch at %0t: bit got %b want %b", $time, act, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// one apb transfer; holds the request until pready is seen high or 20 cycles pass
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		n = 0;
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		// answer is settled mid-cycle and stands until the completing edge
		do begin
			@(negedge ref_clk_in);
			n++;
			rdy = pready_out;
			rd = prdata_out;
			err = pslverr_out;
			@(posedge ref_clk_in);
		end while (rdy !== 1'b1 && n < 20);
		if (rdy !== 1'b1) cmp_bit(1'b0, 1'b1);
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_chk(OFS_CTRL, CTRL_RST);
		rd_chk(OFS_CFG, CFG_RST);
		cmp_bit(pll_powerdown_out, 1'b1);
		cmp({30'h0, pll_bw_out}, {30'h0, BW_MED});
		apb(1'b0, 8'h40, 32'h0);
		cmp({err, rd[30:0]}, 32'h8000_0000);
		wr(OFS_CTRL, 32'h1);
		tick(2);
		cmp_bit(pll_powerdown_out, 1'b0);
	endtask
	// two words back to back, every bit checked in its own cycle
	task automatic ser_check(input logic [1:0] code, input logic [19:0] a, input logic [19:0] b);
		int wtab[4] = '{8, 10, 16, 20};
		int n, i, k;
		logic [39:0] exp;
		n = wtab[code];
		exp = ({20'h0, a} & ((40'h1 << n) - 1)) | ({20'h0, b} << n);
		wr(OFS_CTRL, {26'h0, 1'b0, 1'b0, code, 2'h1});
		tx_word_in <= a;
		tx_word_valid_in <= 1'b1;
		k = 0;
		do begin
			@(negedge ref_clk_in);
			k++;
		end while (tx_word_ready_out !== 1'b1 && k < 40);
		@(posedge ref_clk_in);
		tx_word_in <= b;
		for (i = 0; i < 2 * n; i++) begin
			#1 cmp_bit(tx_serial_out, exp[i]);
			@(posedge ref_clk_in);
			if (i == n - 1) tx_word_valid_in <= 1'b0;
		end
	endtask
	task automatic t_ser;
		for (int c = 0; c < 4; c++) ser_check(c[1:0], 20'h5a3c9, 20'hc6e1b);
		tick(3);
		apb(1'b0, OFS_INT_STAT, 32'h0);
		cmp_bit(rd[IRQ_UNDER], 1'b1);
		wr(OFS_INT_CLR, 32'h1f);
	endtask
	task automatic pulses(input int exp);
		int n;
		n = 0;
		repeat (10) begin
			@(negedge ref_clk_in);
			if (rxdet_pulse_out === 1'b1) n++;
		end
		cmp(n, exp);
	endtask
	task automatic t_idle;
		wr(OFS_CTRL, 32'h3);
		tx_force_elecidle_in <= 1'b1;
		tick(3);
		cmp_bit(tx_serial_oe_out, 1'b0);
		wr(OFS_CTRL, 32'h23);
		pulses(RXDET_PULSE_CYC);
		tick(RXDET_WAIT_CYC + 5);
		apb(1'b0, OFS_STATUS, 32'h0);
		cmp({rd[ST_PRESENT], rd[ST_IDLE]}, 2'h3);
		rd_chk(OFS_INT_STAT, 32'h1 << IRQ_RXDET);
		wr(OFS_INT_CLR, 32'h1f);
		tx_force_elecidle_in <= 1'b0;
		tick(3);
		cmp_bit(tx_serial_oe_out, 1'b1);
		wr(OFS_CTRL, 32'h23);
		pulses(0);
		rd_chk(OFS_INT_STAT, 32'h1 << IRQ_REFUSE);
		wr(OFS_INT_CLR, 32'h1f);
		wr(OFS_CTRL, 32'h1);
		tx_force_elecidle_in <= 1'b1;
		tick(3);
		cmp_bit(tx_serial_oe_out, 1'b1);
		@(posedge ref_clk_in);
		tx_force_elecidle_in <= 1'b0;
	endtask
	task automatic t_cru;
		logic [3:0] tab[5] = '{4'b0011, 4'b0110, 4'b1001, 4'b1101, 4'b0000};
		pll_ref_locked_in <= 1'b1;
		lock_to_data_in <= 1'b1;
		tick(3);
		cmp_bit(rx_pll_locked_out, 1'b1);
		cmp_bit(rx_freqlocked_out, 1'b0);
		wr(OFS_INT_EN, 32'h1);
		freq_in_ppm_in <= 1'b1;
		tick(3);
		cmp_bit(rx_freqlocked_out, 1'b1);
		cmp_bit(irq_out, 1'b1);
		wr(OFS_INT_EN, 32'h0);
		tick(1);
		cmp_bit(irq_out, 1'b0);
		wr(OFS_INT_EN, 32'h1);
		wr(OFS_INT_CLR, 32'h1);
		tick(1);
		cmp_bit(irq_out, 1'b0);
		wr(OFS_CTRL, 32'h11);
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_in);
			{lock_to_data_in, lock_to_ref_in, freq_in_ppm_in} <= tab[i][3:1];
			tick(3);
			cmp_bit(rx_freqlocked_out, tab[i][0]);
		end
		wr(OFS_INT_CLR, 32'h1f);
	endtask
	task automatic t_cfg;
		logic [4:0] mtab[8] = '{5'h01, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14, 5'h19};
		for (int m = 0; m < 8; m++) begin
			wr(OFS_CFG, m | ((m % 3) << 4) | ((m * 2) << 8));
			tick(1);
			cmp({27'h0, pll_mult_out}, {27'h0, mtab[m]});
			cmp(pll_bw_out, m % 3);
			cmp(eq_gain_out, m * 2);
		end
		@(posedge ref_clk_in);
		eq_adapt_level_in <= 4'h9;
		wr(OFS_CFG, 32'h1030);
		tick(2);
		cmp(pll_bw_out, BW_MED);
		cmp(eq_gain_out, 32'h9);
		wr(OFS_CFG, 32'h3000);
		eq_adapt_level_in <= 4'h3;
		tick(2);
		cmp({eq_adapt_pd_out, eq_gain_out}, 32'h19);
		wr(OFS_CFG, 32'h5_0000);
		tick(1);
		cmp(preemph_out, 32'h5);
		@(posedge ref_clk_in);
		reconfig_preemph_in <= 4'ha;
		reconfig_we_in <= 1'b1;
		@(posedge ref_clk_in);
		reconfig_we_in <= 1'b0;
		tick(2);
		cmp(preemph_out, 32'ha);
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{resetn_in, psel_in, penable_in, pwrite_in, tx_word_valid_in} = 5'h0;
		{tx_force_elecidle_in, lock_to_data_in, lock_to_ref_in} = 3'h0;
		{pll_ref_locked_in, freq_in_ppm_in, reconfig_we_in} = 3'h0;
		{paddr_in, pwdata_in, tx_word_in} = 60'h0;
		{eq_adapt_level_in, reconfig_preemph_in} = 8'h0;
		repeat (2) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		t_reset;
		t_ser;
		t_idle;
		t_cru;
		t_cfg;
		close_out;
	end
	initial begin
		#1_000_000;
		mismatches++;
		close_out;
	end
endmodule
`default_nettype wire

// ===== bench/stcl_link_rx.sv
// far-end lane model: answers receiver-detect pulses with a reflection
// assumes detect pulses arrive only from the transmitter on ref_clk_in
`timescale 1ns/100ps
`default_nettype none
module stcl_link_rx #(
	parameter bit PRESENT = 1'b1 // a receiver hangs on the lane
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// lane side
	input wire logic oe_in,
	input wire logic pulse_in,
	// reflection seen by the detector
	output logic reflect_out
);
	logic seen_ff; // pulse hit an idle lane
	logic junk_ff; // toggles so a driven lane gives no steady answer
	// ----------------------------------------
	// reflection memory
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seen_ff <= 1'b0;
			junk_ff <= 1'b0;
		end else begin
			junk_ff <= ~junk_ff;
			if (pulse_in && !oe_in) begin
				seen_ff <= PRESENT;
			end else if (oe_in) begin
				seen_ff <= 1'b0;
			end
		end
	end
	// a driven lane reflects nothing usable
	assign reflect_out = oe_in ? junk_ff : seen_ff;
endmodule
`default_nettype wire

// ===== hw/stcl_channel.sv
// transmit serializer, idle and detect control, clock recovery lock control
// assumes apb master on ref_clk_in and analog status inputs synchronous to it
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module stcl_channel (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// fabric transmit data and pipe control
	input wire logic [stcl_pkg::WORD_W-1:0] tx_word_in,
	input wire logic tx_word_valid_in,
	output logic tx_word_ready_out,
	input wire logic tx_force_elecidle_in,
	// serial transmit pin
	output logic tx_serial_out,
	output logic tx_serial_oe_out,
	// receiver detect analog
	output logic rxdet_pulse_out,
	input wire logic rxdet_reflect_in,
	// lock overrides and analog lock status
	input wire logic lock_to_data_in,
	input wire logic lock_to_ref_in,
	input wire logic pll_ref_locked_in,
	input wire logic freq_in_ppm_in,
	output logic rx_pll_locked_out,
	output logic rx_freqlocked_out,
	output logic pll_powerdown_out,
	// analog settings
	output logic [4:0] pll_mult_out,
	output logic [1:0] pll_bw_out,
	output logic [3:0] eq_gain_out,
	input wire logic [3:0] eq_adapt_level_in,
	output logic eq_adapt_pd_out,
	input wire logic reconfig_we_in,
	input wire logic [3:0] reconfig_preemph_in,
	output logic [3:0] preemph_out,
	// interrupt
	output logic irq_out
);
	import stcl_pkg::*;
	logic [31:0] ctrl_ff, nxt_ctrl; // control register
	logic [31:0] cfg_ff, nxt_cfg; // analog config register
	logic [IRQ_W-1:0] ist_ff, nxt_ist; // sticky event bits
	logic [IRQ_W-1:0] ien_ff, nxt_ien; // event enables
	logic [IRQ_W-1:0] ev; // this cycle's events
	logic [31:0] rdata_ff, nxt_rdata;
	logic err_ff, nxt_err;
	logic [3:0] eq_ff, nxt_eq; // equalizer level in use
	logic [3:0] pre_ff, nxt_pre; // pre-emphasis in use
	logic idle_ff, nxt_idle; // electrical idle state
	logic plock_ff, nxt_plock;
	stcl_cru_t cru_ff, nxt_cru;
	stcl_rxdet_t rd_ff, nxt_rd;
	logic [RXDET_CNT_W-1:0] rdcnt_ff, nxt_rdcnt;
	logic present_ff, nxt_present;
	logic wr, rd, start_req, under;
	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign pready_out = 1'b1;
	assign wr = psel_in && penable_in && pwrite_in;
	assign rd = psel_in && penable_in && !pwrite_in;
	assign start_req = wr && paddr_in == OFS_CTRL && pwdata_in[CTRL_RXDET];
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_cfg = cfg_ff;
		nxt_ien = ien_ff;
		nxt_rdata = rdata_ff;
		nxt_err = 1'b0;
		nxt_ist = ist_ff;
		if (wr) begin
			if (paddr_in == OFS_CTRL) begin
				nxt_ctrl = pwdata_in & 32'h0000_001f; // start bit never stored
			end else if (paddr_in == OFS_CFG) begin
				nxt_cfg[CFG_MULT_LO +: 3] = pwdata_in[CFG_MULT_LO +: 3];
				// reserved bandwidth code is ignored, keeps setting legal
				if (pwdata_in[CFG_BW_LO +: 2] != 2'h3) begin
					nxt_cfg[CFG_BW_LO +: 2] = pwdata_in[CFG_BW_LO +: 2];
				end
				nxt_cfg[CFG_EQ_LO +: 6] = pwdata_in[CFG_EQ_LO +: 6];
				nxt_cfg[CFG_PRE_LO +: 4] = pwdata_in[CFG_PRE_LO +: 4];
			end else if (paddr_in == OFS_INT_CLR) begin
				nxt_ist = ist_ff & ~pwdata_in[IRQ_W-1:0];
			end else if (paddr_in == OFS_INT_EN) begin
				nxt_ien = pwdata_in[IRQ_W-1:0];
			end else if (paddr_in != OFS_STATUS && paddr_in != OFS_INT_STAT) begin
				nxt_err = 1'b1; // unmapped
			end
		end
		// set wins over a clear in the same cycle
		nxt_ist = nxt_ist | ev;
		if (rd) begin
			if (paddr_in == OFS_CTRL) begin
				nxt_rdata = ctrl_ff;
			end else if (paddr_in == OFS_CFG) begin
				nxt_rdata = cfg_ff;
			end else if (paddr_in == OFS_STATUS) begin
				nxt_rdata = '0;
				nxt_rdata[ST_IDLE] = idle_ff;
				nxt_rdata[ST_FLOCK] = cru_ff == CRU_LTD;
				nxt_rdata[ST_PLOCK] = plock_ff;
				nxt_rdata[ST_BUSY] = rd_ff != RD_IDLE;
				nxt_rdata[ST_PRESENT] = present_ff;
				nxt_rdata[ST_PWRDN] = cru_ff == CRU_OFF;
				nxt_rdata[ST_EQ_LO +: 4] = eq_ff;
			end else if (paddr_in == OFS_INT_STAT) begin
				nxt_rdata = {27'h0, ist_ff};
			end else if (paddr_in == OFS_INT_EN) begin
				nxt_rdata = {27'h0, ien_ff};
			end else if (paddr_in == OFS_INT_CLR) begin
				nxt_rdata = '0; // write-only
			end else begin
				nxt_rdata = '0;
				nxt_err = 1'b1;
			end
		end
	end
	// register file flops
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_ff <= CTRL_RST;
			cfg_ff <= CFG_RST;
			ist_ff <= '0;
			ien_ff <= '0;
			rdata_ff <= '0;
			err_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			cfg_ff <= nxt_cfg;
			ist_ff <= nxt_ist;
			ien_ff <= nxt_ien;
			rdata_ff <= nxt_rdata;
			err_ff <= nxt_err;
		end
	end
	// read data is live during the access cycle, then held from the flop
	assign prdata_out = rd ? nxt_rdata : rdata_ff;
	assign pslverr_out = psel_in && penable_in && nxt_err;
	assign irq_out = |(ist_ff & ien_ff);
	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	stcl_serializer u_ser (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.width_code_in(ctrl_ff[CTRL_WID_LO +: 2]),
		.word_in(tx_word_in),
		.word_valid_in(tx_word_valid_in),
		.word_ready_out(tx_word_ready_out),
		.serial_out(tx_serial_out),
		.underrun_out(under)
	);
	// idle only obeys the fabric in pipe mode
	assign nxt_idle = ctrl_ff[CTRL_PIPE] && tx_force_elecidle_in;
	assign tx_serial_oe_out = !idle_ff; // tri-state while idle
	// ----------------------------------------
	// receiver detect sequencer
	// ----------------------------------------
	// a start outside electrical idle is refused, never run
	always_comb begin
		nxt_rd = rd_ff;
		nxt_rdcnt = rdcnt_ff;
		nxt_present = present_ff;
		case (rd_ff)
			RD_IDLE: begin
				if (start_req && idle_ff) begin
					nxt_rd = RD_PULSE;
					nxt_rdcnt = RXDET_CNT_W'(RXDET_PULSE_CYC - 1);
				end
			end
			RD_PULSE: begin
				if (!idle_ff) begin
					nxt_rd = RD_IDLE; // idle lost: abort
				end else if (rdcnt_ff == '0) begin
					nxt_rd = RD_WAIT;
					nxt_rdcnt = RXDET_CNT_W'(RXDET_WAIT_CYC - 1);
				end else begin
					nxt_rdcnt = rdcnt_ff - 1'b1;
				end
			end
			RD_WAIT: begin
				if (!idle_ff) begin
					nxt_rd = RD_IDLE;
				end else if (rdcnt_ff == '0) begin
					nxt_rd = RD_IDLE;
					nxt_present = rxdet_reflect_in;
				end else begin
					nxt_rdcnt = rdcnt_ff - 1'b1;
				end
			end
			default: nxt_rd = RD_IDLE;
		endcase
	end
	// gated by idle so an abort never leaves a pulse on a driven lane
	assign rxdet_pulse_out = rd_ff == RD_PULSE && idle_ff;
	// ----------------------------------------
	// clock recovery lock source
	// ----------------------------------------
	always_comb begin
		nxt_cru = cru_ff;
		if (!ctrl_ff[CTRL_USED]) begin
			nxt_cru = CRU_OFF; // unused channel
		end else if (ctrl_ff[CTRL_OVR] && lock_to_data_in) begin
			nxt_cru = CRU_LTD; // data wins regardless of reference
		end else if (ctrl_ff[CTRL_OVR] && lock_to_ref_in) begin
			nxt_cru = CRU_LTR;
		end else begin
			// automatic, also when overrides are not connected
			case (cru_ff)
				CRU_LTD: if (!freq_in_ppm_in) nxt_cru = CRU_LTR;
				default: begin
					nxt_cru = CRU_LTR;
					// switch only inside the ppm window
					if (cru_ff == CRU_LTR && pll_ref_locked_in && freq_in_ppm_in) begin
						nxt_cru = CRU_LTD;
					end
				end
			endcase
		end
	end
	// follows the next state so power-down clears it at once
	assign nxt_plock = nxt_cru != CRU_OFF && pll_ref_locked_in;
	assign rx_freqlocked_out = cru_ff == CRU_LTD;
	assign rx_pll_locked_out = plock_ff;
	assign pll_powerdown_out = cru_ff == CRU_OFF;
	// ----------------------------------------
	// analog settings
	// ----------------------------------------
	always_comb begin
		nxt_eq = cfg_ff[CFG_EQ_LO +: 4]; // static gain, one of sixteen levels
		if (cfg_ff[CFG_EQ_ADAPT]) begin
			// adaptive result, frozen once the adapter is powered down
			nxt_eq = cfg_ff[CFG_EQ_PD] ? eq_ff : eq_adapt_level_in;
		end
		// run-time reconfiguration beats a same-cycle register write
		nxt_pre = reconfig_we_in ? reconfig_preemph_in : pre_ff;
		if (!reconfig_we_in && wr && paddr_in == OFS_CFG) begin
			nxt_pre = pwdata_in[CFG_PRE_LO +: 4];
		end
	end
	assign pll_mult_out = stcl_mult(cfg_ff[CFG_MULT_LO +: 3]);
	assign pll_bw_out = cfg_ff[CFG_BW_LO +: 2];
	assign eq_gain_out = eq_ff;
	assign eq_adapt_pd_out = cfg_ff[CFG_EQ_PD];
	assign preemph_out = pre_ff;
	// events feeding the sticky status
	always_comb begin
		ev = '0;
		ev[IRQ_LTD_ON] = nxt_cru == CRU_LTD && cru_ff != CRU_LTD;
		ev[IRQ_LTD_OFF] = nxt_cru != CRU_LTD && cru_ff == CRU_LTD;
		ev[IRQ_RXDET] = rd_ff != RD_IDLE && nxt_rd == RD_IDLE;
		ev[IRQ_REFUSE] = start_req && (!idle_ff || rd_ff != RD_IDLE);
		ev[IRQ_UNDER] = under;
	end
	// channel state flops
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			eq_ff <= 4'h0;
			pre_ff <= 4'h0;
			idle_ff <= 1'b0;
			plock_ff <= 1'b0;
			cru_ff <= CRU_OFF;
			rd_ff <= RD_IDLE;
			rdcnt_ff <= '0;
			present_ff <= 1'b0;
		end else begin
			eq_ff <= nxt_eq;
			pre_ff <= nxt_pre;
			idle_ff <= nxt_idle;
			plock_ff <= nxt_plock;
			cru_ff <= nxt_cru;
			rd_ff <= nxt_rd;
			rdcnt_ff <= nxt_rdcnt;
			present_ff <= nxt_present;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	a_idle_tristate: assert property (ctrl_ff[CTRL_PIPE] && tx_force_elecidle_in
		|=> !tx_serial_oe_out) else $error("buffer driven during forced idle");
	a_rxdet_in_idle: assert property ($rose(rxdet_pulse_out)
		|-> $past(idle_ff) && !tx_serial_oe_out)
		else $error("detect pulse while buffer drives");
	a_rxdet_pulse_len: assert property (idle_ff && $rose(rxdet_pulse_out)
		##1 idle_ff [*3] |-> rxdet_pulse_out && $past(rxdet_pulse_out)
		&& $past(rxdet_pulse_out, 2) ##1 !rxdet_pulse_out)
		else $error("detect pulse not four cycles");
	a_force_data: assert property (ctrl_ff[CTRL_USED] && ctrl_ff[CTRL_OVR]
		&& lock_to_data_in |=> rx_freqlocked_out) else $error("data override ignored");
	a_force_ref: assert property (ctrl_ff[CTRL_OVR] && !lock_to_data_in
		&& lock_to_ref_in |=> !rx_freqlocked_out) else $error("reference override ignored");
	a_auto_default: assert property (!ctrl_ff[CTRL_OVR] && cru_ff == CRU_LTR
		&& !(pll_ref_locked_in && freq_in_ppm_in) |=> !rx_freqlocked_out)
		else $error("unconnected overrides not automatic");
	a_auto_ppm: assert property ($rose(rx_freqlocked_out) && !$past(ctrl_ff[CTRL_OVR])
		|-> $past(freq_in_ppm_in) && $past(pll_ref_locked_in))
		else $error("auto switch outside ppm window");
	a_flock_power: assert property (rx_freqlocked_out |-> !pll_powerdown_out)
		else $error("data lock while powered down");
	a_pll_lock: assert property (ctrl_ff[CTRL_USED] && $past(ctrl_ff[CTRL_USED])
		|-> rx_pll_locked_out == $past(pll_ref_locked_in)) else $error("pll lock wrong");
	a_unused_off: assert property (!ctrl_ff[CTRL_USED] |=> pll_powerdown_out
		&& !rx_freqlocked_out && !rx_pll_locked_out) else $error("unused channel alive");
	a_eq_hold: assert property (cfg_ff[CFG_EQ_ADAPT] && cfg_ff[CFG_EQ_PD]
		&& $past(cfg_ff[CFG_EQ_PD]) |=> $stable(eq_gain_out)) else $error("eq level moved");
	c_rxdet_done: cover property (rd_ff == RD_WAIT ##1 rd_ff == RD_IDLE);
	c_ltd_enter: cover property (!ctrl_ff[CTRL_OVR] ##1 $rose(rx_freqlocked_out));
	c_underrun: cover property (under);
	c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

// ===== hw/stcl_serializer.sv
// parallel to serial shifter, one serial bit per clock, lsb first
// assumes width changes are wanted only at word boundaries
`timescale 1ns/100ps
`default_nettype none
module stcl_serializer (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// word side
	input wire logic [1:0] width_code_in,
	input wire logic [stcl_pkg::WORD_W-1:0] word_in,
	input wire logic word_valid_in,
	output logic word_ready_out,
	// serial side
	output logic serial_out,
	output logic underrun_out
);
	import stcl_pkg::*;
	logic [WORD_W-1:0] shreg_ff, nxt_shreg;
	logic [4:0] cnt_ff, nxt_cnt; // bits still to send after current
	logic active_ff, nxt_active;
	logic serial_ff, nxt_serial;
	logic under_ff, nxt_under;
	// ----------------------------------------
	// load and shift
	// ----------------------------------------
	// ready on the last bit lets the next word follow with no gap
	assign word_ready_out = !active_ff || (cnt_ff == 5'h00);
	always_comb begin
		nxt_shreg = {1'b0, shreg_ff[WORD_W-1:1]};
		nxt_cnt = cnt_ff - 5'h01;
		nxt_active = active_ff;
		nxt_serial = shreg_ff[0];
		nxt_under = 1'b0;
		if (word_ready_out) begin
			if (word_valid_in) begin
				// bit zero leaves first, msb last
				nxt_serial = word_in[0];
				nxt_shreg = {1'b0, word_in[WORD_W-1:1]};
				nxt_cnt = stcl_width(width_code_in) - 5'h01;
				nxt_active = 1'b1;
			end else begin
				// starved: line drops low, flagged once per gap
				nxt_serial = 1'b0;
				nxt_cnt = 5'h00;
				nxt_active = 1'b0;
				nxt_under = active_ff;
			end
		end
	end
	// registers only
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			shreg_ff <= '0;
			cnt_ff <= 5'h00;
			active_ff <= 1'b0;
			serial_ff <= 1'b0;
			under_ff <= 1'b0;
		end else begin
			shreg_ff <= nxt_shreg;
			cnt_ff <= nxt_cnt;
			active_ff <= nxt_active;
			serial_ff <= nxt_serial;
			under_ff <= nxt_under;
		end
	end
	assign serial_out = serial_ff;
	assign underrun_out = under_ff;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_lsb_first: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		word_valid_in && word_ready_out |=> serial_out == $past(word_in[0]))
		else $error("first serial bit is not bit zero");
	a_word_gapless: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		word_valid_in && word_ready_out && width_code_in == WID_8
		|=> !word_ready_out [*7] ##1 word_ready_out)
		else $error("8-bit word not sent in 8 cycles");
endmodule
`default_nettype wire

// ===== include/stcl_pkg.sv
// constants, codes and state types for one transceiver channel control block
// assumes a 40 MHz control clock and a 32-bit apb register bus
package stcl_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int RXDET_PULSE_NS = 100; // detect pulse width, least time
	localparam int RXDET_WAIT_NS = 500; // reflection settle time, least time
	localparam int RXDET_PULSE_CYC = (RXDET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXDET_WAIT_CYC = (RXDET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RXDET_CNT_W = 5;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_INT_STAT = 8'h0c;
	localparam logic [7:0] OFS_INT_CLR = 8'h10;
	localparam logic [7:0] OFS_INT_EN = 8'h14;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int CTRL_USED = 0;
	localparam int CTRL_PIPE = 1;
	localparam int CTRL_WID_LO = 2; // two bits
	localparam int CTRL_OVR = 4; // lock override ports connected
	localparam int CTRL_RXDET = 5; // write one to start detection
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// ----------------------------------------
	// config register fields
	// ----------------------------------------
	localparam int CFG_MULT_LO = 0; // three bits
	localparam int CFG_BW_LO = 4; // two bits
	localparam int CFG_EQ_LO = 8; // four bits
	localparam int CFG_EQ_ADAPT = 12;
	localparam int CFG_EQ_PD = 13;
	localparam int CFG_PRE_LO = 16; // four bits
	localparam logic [31:0] CFG_RST = 32'h0000_0010;
	// ----------------------------------------
	// status and interrupt bits
	// ----------------------------------------
	localparam int ST_IDLE = 0;
	localparam int ST_FLOCK = 1;
	localparam int ST_PLOCK = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_PRESENT = 4;
	localparam int ST_PWRDN = 5;
	localparam int ST_EQ_LO = 8;
	localparam int IRQ_W = 5;
	localparam int IRQ_LTD_ON = 0;
	localparam int IRQ_LTD_OFF = 1;
	localparam int IRQ_RXDET = 2;
	localparam int IRQ_REFUSE = 3;
	localparam int IRQ_UNDER = 4;
	// ----------------------------------------
	// data widths and codes
	// ----------------------------------------
	localparam int WORD_W = 20;
	localparam logic [1:0] WID_8 = 2'h0;
	localparam logic [1:0] WID_10 = 2'h1;
	localparam logic [1:0] WID_16 = 2'h2;
	localparam logic [1:0] WID_20 = 2'h3;
	localparam logic [1:0] BW_LOW = 2'h0;
	localparam logic [1:0] BW_MED = 2'h1;
	localparam logic [1:0] BW_HIGH = 2'h2;
	typedef enum logic [1:0] {CRU_OFF, CRU_LTR, CRU_LTD} stcl_cru_t;
	typedef enum logic [1:0] {RD_IDLE, RD_PULSE, RD_WAIT} stcl_rxdet_t;
	// serial bits per parallel word
	function automatic logic [4:0] stcl_width(input logic [1:0] code);
		case (code)
			WID_8: stcl_width = 5'h08;
			WID_10: stcl_width = 5'h0a;
			WID_16: stcl_width = 5'h10;
			default: stcl_width = 5'h14;
		endcase
	endfunction
	// pll multiplication factor for each code
	function automatic logic [4:0] stcl_mult(input logic [2:0] code);
		case (code)
			3'h0: stcl_mult = 5'h01;
			3'h1: stcl_mult = 5'h04;
			3'h2: stcl_mult = 5'h05;
			3'h3: stcl_mult = 5'h08;
			3'h4: stcl_mult = 5'h0a;
			3'h5: stcl_mult = 5'h10;
			3'h6: stcl_mult = 5'h14;
			default: stcl_mult = 5'h19;
		endcase
	endfunction
endpackage
